// ### hw/tmc_timer_counter.sv
// Purpose: 18-bit timer, event, pulse width and frequency counter with APB registers
// Assumes: fc_tick and fs_tick are one-cycle pulses on pclk; ext and gate pins are asynchronous
// Notes:   answers each APB access after one access cycle; compare reads return the live counter
//
// The APB register port is this design's own decision.

`timescale 1ns/1ps
`default_nettype none

module tmc_timer_counter (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       fc_tick,
    input  wire logic                       fs_tick,
    input  wire logic [1:0]                 power_mode,
    input  wire logic                       divider_option,
    input  wire logic                       ext_count_input,
    input  wire logic                       companion_pwm_out,
    output logic                            timer_irq,
    output logic                            companion_port_pin_o,
    output logic                            companion_port_pin_oe
);
    import tmc_pkg::*;

    // ******************************************************************
    // helpers
    // ******************************************************************

    // a tap ticks when the low divider bits are all ones
    function automatic logic tap_hit(input logic [FC_DIV_W-1:0] div, input int n);
        logic [FC_DIV_W-1:0] mask;
        mask = FC_DIV_W'((64'h1 << n) - 64'h1);
        return &(div | ~mask);
    endfunction

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return ADDR_W'({idx, 2'b00});
    endfunction

    // ******************************************************************
    // registers and state
    // ******************************************************************
    tmc_ctl1_type          ctl1_ff;
    tmc_ctl2_type          ctl2_ff;
    logic [7:0]            gatep_ff;
    logic [17:0]           cmp_ff;
    logic                  cmp_en_ff;

    logic [17:0]           cnt_ff;
    logic                  ovf_ff;

    logic [FC_DIV_W-1:0]   fc_div_ff;
    logic [FS_DIV_W-1:0]   fs_div_ff;

    logic                  ext_s1_ff;
    logic                  ext_s2_ff;
    logic                  ext_s3_ff;

    tmc_gate_type          wg_state_ff;
    logic [3:0]            wg_cnt_ff;
    logic                  gate_eff_ff;

    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;

    logic                  irq_ff;
    logic                  pin_o_ff;
    logic                  pin_oe_ff;

    // ******************************************************************
    // bus decode
    // ******************************************************************

    // answer registered in setup: bus outputs come from flops
    wire logic setup_ph   = psel & ~penable;
    wire logic wr_ok      = psel & penable & pready_ff & pwrite;

    wire logic hit_ctl1   = paddr == byte_addr(CTL1_IDX);
    wire logic hit_ctl2   = paddr == byte_addr(CTL2_IDX);
    wire logic hit_stat   = paddr == byte_addr(STAT_IDX);
    wire logic hit_cmpl   = paddr == byte_addr(CMPL_IDX);
    wire logic hit_cmpm   = paddr == byte_addr(CMPM_IDX);
    wire logic hit_cmph   = paddr == byte_addr(CMPH_IDX);
    wire logic hit_gatep  = paddr == byte_addr(GATEP_IDX);

    wire logic hit_any    = hit_ctl1 | hit_ctl2 | hit_stat | hit_cmpl | hit_cmpm | hit_cmph | hit_gatep;

    wire logic sw_clear   = wr_ok & hit_ctl1 & ~pwdata[7];                   // [RL1]
    wire logic running    = ctl1_ff.run_control == RUN_GO;

    // ******************************************************************
    // count source selection
    // ******************************************************************

    // two sync flops, then a third as edge history
    wire logic ext_lvl    = ext_s2_ff;
    wire logic ext_fall   = ext_s3_ff & ~ext_s2_ff;
    wire logic ext_rise   = ~ext_s3_ff & ext_s2_ff;
    wire logic ext_edge   = ext_fall | (ctl2_ff.ext_edge_sel & ext_rise);        // [RL12]

    wire logic low_clk    = divider_option | (power_mode != PWR_NORMAL);
    wire logic fs_on      = power_mode == PWR_NORMAL;
    wire logic [FC_DIV_W-1:0] fs_wide = FC_DIV_W'(fs_div_ff);

    wire logic fc_t23     = fc_tick & tap_hit(fc_div_ff, FC_T23);
    wire logic fc_t13     = fc_tick & tap_hit(fc_div_ff, FC_T13);
    wire logic fc_t11     = fc_tick & tap_hit(fc_div_ff, FC_T11);
    wire logic fc_t7      = fc_tick & tap_hit(fc_div_ff, FC_T7);
    wire logic fc_t3      = fc_tick & tap_hit(fc_div_ff, FC_T3);

    wire logic fs_t15     = fs_tick & tap_hit(fs_wide, FS_T15);
    wire logic fs_t5      = fs_tick & tap_hit(fs_wide, FS_T5);
    wire logic fs_t3      = fs_tick & tap_hit(fs_wide, FS_T3);

    logic      src_tick;

    // low-clock settings move the fc/2^23, fc/2^13 and fc/2^11 taps to fs taps; empty table cells give no tick
    always_comb begin
        unique case (ctl1_ff.count_source_sel)                                    // [RL3]
            SRC_FC:  src_tick = fc_tick;
            SRC_FS:  src_tick = fs_on & fs_tick;
            SRC_D23: src_tick = low_clk ? fs_t15 : fc_t23;
            SRC_D13: src_tick = low_clk ? fs_t5 : fc_t13;
            SRC_D11: src_tick = low_clk ? fs_t3 : fc_t11;
            SRC_D7:  src_tick = fs_on & fc_t7;
            SRC_D3:  src_tick = fs_on & fc_t3;
            SRC_EXT: src_tick = ext_edge;
        endcase
    end

    // ******************************************************************
    // window gate
    // ******************************************************************
    logic wg_tick;

    // time base taps of the internal window gate; the reserved code stalls the gate
    always_comb begin
        unique case (ctl2_ff.gate_timebase_sel)                                   // [RL16]
            2'b00:   wg_tick = low_clk ? fs_tick & tap_hit(fs_wide, WG_FS0)
                                       : fc_tick & tap_hit(fc_div_ff, WG_FC0);
            2'b01:   wg_tick = low_clk ? fs_tick & tap_hit(fs_wide, WG_FS0 + 1)
                                       : fc_tick & tap_hit(fc_div_ff, WG_FC0 + 1);
            2'b10:   wg_tick = low_clk ? fs_tick & tap_hit(fs_wide, WG_FS0 + 2)
                                       : fc_tick & tap_hit(fc_div_ff, WG_FC0 + 2);
            2'b11:   wg_tick = 1'b0;
        endcase
    end

    wire logic int_gate   = wg_state_ff == GATE_HIGH;
    wire logic wg_turn    = wg_tick & (wg_cnt_ff == GATE_LAST);
    wire logic wg_run     = running & (ctl1_ff.operating_mode_sel == MODE_FREQ);

    wire logic [3:0] ta   = gatep_ff[7:4];
    wire logic [3:0] tb   = gatep_ff[3:0];

    wire logic sel_gate   = (ctl2_ff.gate_source_sel == GSRC_INT) ? int_gate :
                            (ctl2_ff.gate_source_sel == GSRC_CMP) ? companion_pwm_out :
                            ext_lvl;                                                   // [RL14]

    wire logic meas_gate  = (ctl1_ff.operating_mode_sel == MODE_PWIDTH) ? ext_lvl : sel_gate;

    wire logic gate_now   = running & meas_gate;
    wire logic gate_fall  = gate_eff_ff & ~gate_now;
    wire logic gate_rise  = ~gate_eff_ff & gate_now;

    // ******************************************************************
    // counter, compare and overflow
    // ******************************************************************
    wire logic is_timer   = ctl1_ff.operating_mode_sel == MODE_TIMER;            // [RL4]
    wire logic is_meas    = (ctl1_ff.operating_mode_sel == MODE_PWIDTH) |
                            (ctl1_ff.operating_mode_sel == MODE_FREQ);

    wire logic cnt_step   = running & src_tick & (is_timer | (is_meas & gate_now));
    wire logic [17:0] cnt_inc = cnt_ff + 18'h00001;

    wire logic match      = is_timer & cmp_en_ff & cnt_step & (cnt_inc == cmp_ff);
    wire logic wrap       = cnt_step & (cnt_ff == CNT_MAX);

    wire logic gate_irq   = is_meas & (gate_fall | (ctl2_ff.gate_irq_edge_sel & gate_rise));

    logic [17:0] nxt_cnt;

    // stop clears the counter; match restarts from zero; measurement keeps its count
    always_comb begin
        if (sw_clear | ~running | match) begin
            nxt_cnt = '0;                                                        // [RL1] [RL21]
        end else if (cnt_step) begin
            nxt_cnt = cnt_inc;
        end else begin
            nxt_cnt = cnt_ff;
        end
    end

    // ******************************************************************
    // read data
    // ******************************************************************
    logic [7:0] rd_byte;

    // compare addresses read the live counter
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctl1) begin
            rd_byte = ctl1_ff;
        end else if (hit_ctl2) begin
            rd_byte = ctl2_ff;
        end else if (hit_stat) begin
            rd_byte = {wg_run & int_gate & (ctl2_ff.gate_source_sel == GSRC_INT) |
                       (is_meas & ~(ctl1_ff.operating_mode_sel == MODE_PWIDTH) & gate_now),
                       ovf_ff, 6'h00};                                             // [RL19] [RL20]
        end else if (hit_cmpl) begin
            rd_byte = cnt_ff[7:0];                                               // [RL7]
        end else if (hit_cmpm) begin
            rd_byte = cnt_ff[15:8];
        end else if (hit_cmph) begin
            rd_byte = {6'h00, cnt_ff[17:16]};                                    // [RL11]
        end else if (hit_gatep) begin
            rd_byte = gatep_ff;
        end
    end

    // ******************************************************************
    // bus and control registers
    // ******************************************************************

    // counter clear is a strobe: the stored bit always returns to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_ff   <= CTL1_RST;
            ctl2_ff   <= CTL2_RST;
            gatep_ff  <= GATEP_RST;
            cmp_ff    <= CMP_RST;
            cmp_en_ff <= 1'b1;
        end else if (wr_ok) begin
            if (hit_ctl1) ctl1_ff <= {1'b1, pwdata[6:0]};                        // [RL1]
            if (hit_ctl2) ctl2_ff <= pwdata[7:0];
            if (hit_gatep) gatep_ff <= pwdata[7:0];

            if (hit_cmpl) cmp_ff[7:0] <= pwdata[7:0];
            if (hit_cmpm) cmp_ff[15:8] <= pwdata[7:0];
            if (hit_cmph) cmp_ff[17:16] <= pwdata[1:0];                          // [RL11]

            if (hit_cmpl | hit_cmpm) cmp_en_ff <= 1'b0;                          // [RL5]
            if (hit_cmph) cmp_en_ff <= 1'b1;                                     // [RL5]
        end
    end

    // one access cycle per transfer; unmapped addresses answer with an error and zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph & ~hit_any;
            prdata_ff  <= setup_ph ? {24'h000000, rd_byte} : '0;
        end
    end

    // ******************************************************************
    // counting datapath
    // ******************************************************************

    // overflow: a wrap in the same cycle as the software clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff      <= '0;
            ovf_ff      <= 1'b0;

            fc_div_ff   <= '0;
            fs_div_ff   <= '0;

            ext_s1_ff   <= 1'b0;
            ext_s2_ff   <= 1'b0;
            ext_s3_ff   <= 1'b0;

            gate_eff_ff <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            ovf_ff      <= wrap | (ovf_ff & ~sw_clear);                           // [RL20] [RL1]

            fc_div_ff   <= fc_tick ? fc_div_ff + 1'b1 : fc_div_ff;
            fs_div_ff   <= fs_tick ? fs_div_ff + 1'b1 : fs_div_ff;

            ext_s1_ff   <= ext_count_input;
            ext_s2_ff   <= ext_s1_ff;
            ext_s3_ff   <= ext_s2_ff;

            gate_eff_ff <= gate_now;
        end
    end

    // internal window gate: high for 16-ta time base ticks, then low for 16-tb
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wg_state_ff <= GATE_LOW;
            wg_cnt_ff   <= '0;
        end else if (!wg_run) begin
            wg_state_ff <= GATE_HIGH;
            wg_cnt_ff   <= ta;
        end else if (wg_turn) begin
            wg_state_ff <= int_gate ? GATE_LOW : GATE_HIGH;
            wg_cnt_ff   <= int_gate ? tb : ta;
        end else if (wg_tick) begin
            wg_cnt_ff   <= wg_cnt_ff + 4'h1;
        end
    end

    // ******************************************************************
    // interrupt and companion pin
    // ******************************************************************

    // irq is a one-pulse strobe; the interrupt controller latches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff    <= 1'b0;
            pin_o_ff  <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            irq_ff    <= match | gate_irq;                                       // [RL21] [RL15] [RL22]
            pin_o_ff  <= companion_pwm_out;
            pin_oe_ff <= ~ctl2_ff.companion_output_route;                        // [RL17]
        end
    end

    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;

    assign timer_irq             = irq_ff;
    assign companion_port_pin_o  = pin_o_ff;
    assign companion_port_pin_oe = pin_oe_ff;

endmodule

`default_nettype wire

// ### hw/tmc_pkg.sv
// Purpose: constants and types of the timer/counter block
// Assumes: APB slave on pclk; fc and fs arrive as one-cycle enable ticks on pclk
// Notes:   register byte address is four times the register index
//
// What this block does
// (RL1) clear bit 0 zeroes counter and overflow, then reads 1 again
// (RL2) software changes settings only while stopped; 10 runs, x1 reserved
// (RL3) source: fc, fs or taps by option and power mode; 111 external
// (RL4) mode 00 timer/event, 10 pulse width, 11 frequency, 01 reserved
// (RL5) a low or mid compare write blocks matching until the high byte
// (RL6) software picks undivided fc only for slow timer or normal pulse width
// (RL7) compare reads return the live counter
// (RL8) software loads compare with at least 1, no read-modify-write
// (RL9) software: internal source for timer and pulse width, external for events
// (RL10) software avoids fc/2^7 and fc/2^3 taps in slow or sleep mode
// (RL11) high compare bits 7..2 read 0 and ignore ones
// (RL12) edge select 0 counts falling edges, 1 both edges
// (RL13) software keeps edge select 0 in event and pulse width operation
// (RL14) gate source: external, internal window gate or companion output
// (RL15) gate irq edge 0: falling edge, 1: both edges
// (RL16) time base 00/01/10: 2^12/13/14 fc or 2^4/5/6 fs; 11 reserved
// (RL17) companion route 0 drives the pin, 1 withholds it
// (RL18) software writes 0 to bit 0 of control two
// (RL19) activity monitor is 1 while counting in the gate high period of frequency mode
// (RL20) wrap from maximum sets overflow until counter clear
// (RL21) timer/event match raises irq and restarts the counter
// (RL22) irq is a one-cycle pulse on pclk

package tmc_pkg;

    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [7:0] CTL1_IDX   = 8'h14;
    localparam logic [7:0] CTL2_IDX   = 8'h15;
    localparam logic [7:0] STAT_IDX   = 8'h16;
    localparam logic [7:0] CMPL_IDX   = 8'h10;
    localparam logic [7:0] CMPM_IDX   = 8'h11;
    localparam logic [7:0] CMPH_IDX   = 8'h12;
    localparam logic [7:0] GATEP_IDX  = 8'h13;
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] CTL1_RST   = 8'h88;
    localparam logic [7:0] CTL2_RST   = 8'h00;
    localparam logic [7:0] GATEP_RST  = 8'h00;
    localparam logic [17:0] CMP_RST   = 18'h3ffff;
    localparam logic [17:0] CNT_MAX   = 18'h3ffff;
    localparam logic [3:0] GATE_LAST  = 4'hf;

    // ******************************************************************
    // prescaler taps
    // ******************************************************************
    localparam int FC_DIV_W = 23;
    localparam int FS_DIV_W = 15;
    localparam int FC_T23 = 23;
    localparam int FC_T13 = 13;
    localparam int FC_T11 = 11;
    localparam int FC_T7  = 7;
    localparam int FC_T3  = 3;
    localparam int FS_T15 = 15;
    localparam int FS_T5  = 5;
    localparam int FS_T3  = 3;
    localparam int WG_FC0 = 12;
    localparam int WG_FS0 = 4;

    // ******************************************************************
    // encodings
    // ******************************************************************
    localparam logic [1:0] RUN_GO   = 2'b10;
    localparam logic [2:0] SRC_FC   = 3'b000;
    localparam logic [2:0] SRC_FS   = 3'b001;
    localparam logic [2:0] SRC_D23  = 3'b010;
    localparam logic [2:0] SRC_D13  = 3'b011;
    localparam logic [2:0] SRC_D11  = 3'b100;
    localparam logic [2:0] SRC_D7   = 3'b101;
    localparam logic [2:0] SRC_D3   = 3'b110;
    localparam logic [2:0] SRC_EXT  = 3'b111;
    localparam logic [1:0] GSRC_INT = 2'b10;
    localparam logic [1:0] GSRC_CMP = 2'b11;
    localparam logic [1:0] PWR_NORMAL = 2'b00;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_RSV   = 2'b01,
        MODE_PWIDTH = 2'b10,
        MODE_FREQ  = 2'b11
    } tmc_mode_type;

    typedef enum logic {
        GATE_LOW  = 1'b0,
        GATE_HIGH = 1'b1
    } tmc_gate_type;

    typedef struct packed {
        logic         counter_clear_ctl;
        logic [1:0]   run_control;
        logic [2:0]   count_source_sel;
        tmc_mode_type operating_mode_sel;
    } tmc_ctl1_type;

    typedef struct packed {
        logic       ext_edge_sel;
        logic [1:0] gate_source_sel;
        logic       gate_irq_edge_sel;
        logic [1:0] gate_timebase_sel;
        logic       companion_output_route;
        logic       bit_zero;
    } tmc_ctl2_type;

endpackage

// ### verif/tmc_timer_counter_assertions.sv
// Purpose: port checks of the timer block
// Assumes: APB answers in the first access cycle after setup
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_counter_assertions (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       timer_irq,
    input wire logic                       companion_port_pin_oe
);
    import tmc_pkg::*;
    logic wr_ctl2;
    // ************************************************************
    // helpers and defaults
    // ************************************************************
    assign wr_ctl2 = pready & psel & penable & pwrite & (paddr == 8'h54);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ************************************************************
    // properties
    // ************************************************************
    property p_ready_after_setup; psel && !penable |=> pready && penable; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready too long");
    property p_irq_pulse; timer_irq |=> !timer_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    property p_err_mapped; pready && paddr inside {[8'h40:8'h58]} |-> !pslverr; endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("error on mapped");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data outside access");
    property p_stat_zero; pready && !pwrite && paddr == 8'h58 |-> prdata[31:8] == 0 && prdata[5:0] == 0; endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("status spare set");
    property p_cmph_mask; pready && !pwrite && paddr == 8'h48 |-> prdata[31:2] == 30'h0; endproperty
    a_cmph_mask: assert property (p_cmph_mask) else $error("cmp high spare set");
    // route output moves only after a control two write
    property p_route_write;
        !$stable(companion_port_pin_oe) && $past(presetn, 3) |-> $past(wr_ctl2) || $past(wr_ctl2, 2);
    endproperty
    a_route_write: assert property (p_route_write) else $error("route moved alone");
    // stop and clear, then a compare read sees zero
    property p_clear;
        (pready && pwrite && paddr == 8'h50 && pwdata[7:5] == 3'b000) ##[1:2]
        (psel && !penable && !pwrite && paddr == 8'h40) ##1 pready |-> prdata == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");
endmodule
`default_nettype wire

// ### verif/tb_timer_counter_18bit_control.sv
// Purpose: self-checking bench of the timer block
// Assumes: fc tick held high in the timer checks, so the fc/2^3 tap ticks every 8 cycles
// Notes:   fs, power mode and divider option stay at normal values
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter_18bit_control;
    import tmc_pkg::*;
    typedef struct packed { logic [7:0] addr; logic [31:0] exp; logic err; } tmc_row_type;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, timer_irq, pin_o, pin_oe;
    logic        fc_tick = 1'b0, ext_in = 1'b1, pwm = 1'b0;
    int          n_errors = 0, samples_checked = 0, irq_n = 0, n0;
    logic [31:0] r;
    logic        e;
    // reset values and an unmapped place, read back in one loop
    tmc_row_type rows [8] = '{'{8'h50, 32'h88, 1'b0}, '{8'h54, 32'h0, 1'b0}, '{8'h58, 32'h0, 1'b0},
        '{8'h40, 32'h0, 1'b0}, '{8'h44, 32'h0, 1'b0}, '{8'h48, 32'h0, 1'b0}, '{8'h4c, 32'h0, 1'b0},
        '{8'h7c, 32'h0, 1'b1}};
    // ************************************************************
    // clock, design and irq tally
    // ************************************************************
    initial begin
        forever #4 pclk = ~pclk;
    end
    tmc_timer_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fc_tick(fc_tick),
        .fs_tick(1'b0), .power_mode(PWR_NORMAL), .divider_option(1'b0), .ext_count_input(ext_in),
        .companion_pwm_out(pwm), .timer_irq(timer_irq), .companion_port_pin_o(pin_o),
        .companion_port_pin_oe(pin_oe));
    // nba: a read at an edge sees the old total
    always @(posedge pclk) begin
        if (timer_irq === 1'b1) irq_n <= irq_n + 1;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            $display("wrong value %s expected %h seen %h", nm, ex, got);
            n_errors++;
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // a hang is cut short well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            rd(rows[i].addr);
            chk("read", rows[i].exp, r);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
        end
        wr(8'h58, 32'hff);
        rd(8'h58);
        chk("status", 32'h0, r);
        wr(8'h48, 32'hff);
        rd(8'h48);
        chk("cmp high", 32'h0, r);
        // timer on the fc/2^3 tap: bare fc is not for normal-mode timing
        wr(8'h40, 32'h5);
        wr(8'h44, 32'h0);
        wr(8'h48, 32'h0);
        fc_tick <= 1'b1;
        wr(8'h50, 32'h98);
        wr(8'h50, 32'hd8);
        n0 = irq_n;
        repeat (80) @(posedge pclk);
        chk("irq period five", 32'd2, irq_n - n0);
        // a lone low byte write holds matching off until the high byte
        wr(8'h40, 32'h2);
        n0 = irq_n;
        repeat (80) @(posedge pclk);
        chk("irq held off", 32'd0, irq_n - n0);
        wr(8'h48, 32'h0);
        wr(8'h50, 32'h58);
        rd(8'h50);
        chk("clear bit back", 32'hd8, r);
        n0 = irq_n;
        repeat (80) @(posedge pclk);
        chk("irq period two", 32'd5, irq_n - n0);
        fc_tick <= 1'b0;
        pwm <= 1'b1;
        // event mode on falling edges, then both edges in frequency mode gated by the companion
        for (int s = 0; s < 2; s++) begin
            wr(8'h50, s ? 32'h1f : 32'h1c);
            rd(8'h40);
            chk("cleared", 32'h0, r);
            wr(8'h40, 32'hff);
            wr(8'h44, 32'hff);
            wr(8'h48, 32'h03);
            wr(8'h54, s ? 32'he0 : 32'h0);
            wr(8'h50, s ? 32'hdf : 32'hdc);
            repeat (4) begin
                ext_in <= 1'b0;
                repeat (4) @(posedge pclk);
                ext_in <= 1'b1;
                repeat (4) @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            rd(8'h40);
            chk("edge count", s ? 32'd8 : 32'd4, r);
        end
        // frequency mode gated by the pin: monitor and gate-edge irqs
        for (int g = 0; g < 2; g++) begin
            wr(8'h50, 32'h1f);
            wr(8'h54, g ? 32'h10 : 32'h0);
            wr(8'h50, 32'hdf);
            n0 = irq_n;
            ext_in <= 1'b1;
            repeat (6) @(posedge pclk);
            rd(8'h58);
            chk("monitor high", 32'h80, r);
            ext_in <= 1'b0;
            repeat (8) @(posedge pclk);
            rd(8'h58);
            chk("monitor low", 32'h0, r);
            chk("gate irqs", g + 1, irq_n - n0);
        end
        // companion output routing to the port pin
        wr(8'h54, 32'h2);
        repeat (3) @(posedge pclk);
        chk("route off", 32'h0, {31'h0, pin_oe});
        wr(8'h54, 32'h0);
        repeat (3) @(posedge pclk);
        chk("route on", 32'h3, {30'h0, pin_oe, pin_o});
        // second reset in mid-run restores the control reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h50);
        chk("ctl1 after reset", 32'h88, r);
        give_verdict();
    end
endmodule
bind tmc_timer_counter tmc_timer_counter_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_irq(timer_irq), .companion_port_pin_oe(companion_port_pin_oe));
`default_nettype wire
